// ===== inc/sswr_pkg.sv
// Shared constants and types of the low-power serial receive block.
// Assumes a 100 MHz APB clock and 32-bit word registers.
package sswr_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_STANDBY  = 8'h00; // serial_standby_control
    localparam logic [7:0] OFS_START    = 8'h04; // channel_start_register
    localparam logic [7:0] OFS_STOP     = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_CH0_DATA = 8'h10;
    localparam logic [7:0] OFS_CH1_DATA = 8'h14; // chan1_data_register
    localparam logic [7:0] OFS_PRESCALE = 8'h18; // clock_prescaler_select
    localparam logic [7:0] OFS_MODE     = 8'h1C;

    // Field positions
    localparam int SSC_WAKE_BIT     = 0;
    localparam int SSC_SUPPRESS_BIT = 1;
    localparam int CH0_TRIG_BIT     = 0;
    localparam int CH1_TRIG_BIT     = 1;
    localparam int MODE_EIE_BIT     = 0;
    localparam int MODE_PARITY_BIT  = 1;
    localparam int ERR_PEF_BIT      = 4;
    localparam int ERR_FEF_BIT      = 5;
    localparam int ERR_OVE_BIT      = 6;
    localparam int DIV_LSB          = 9;
    localparam int DIV_MSB          = 15;

    // Widths and reset values
    localparam int         PS_W         = 4;
    localparam int         DIV_W        = 7;
    localparam int         CNT_W        = 24;
    localparam logic [3:0] RST_PRESCALE = 4'h0;
    localparam logic [6:0] RST_DIV      = 7'h00;
    localparam logic [3:0] LAST_DATA    = 4'h8;
    localparam logic [3:0] PARITY_SLOT  = 4'h9;
    localparam logic [3:0] STOP_SLOT    = 4'hA;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_CSI   = 4'b0100,
        ST_UART  = 4'b1000
    } sswr_mode_t;

    typedef struct packed {
        sswr_mode_t        mode;
        logic              wake_en;
        logic              suppress;
        logic              eie;
        logic              parity_en;
        logic              en0;
        logic              en1;
        logic [PS_W-1:0]   ps;
        logic [DIV_W-1:0]  div;
        logic [7:0]        ch0_data;
        logic [7:0]        ch1_data;
        logic [7:0]        shift;
        logic [3:0]        bitcnt;
        logic [CNT_W-1:0]  baud;
        logic              par_acc;
        logic              buf_full;
        logic              ovf1;
        logic              pef;
        logic              fef;
        logic              ove;
        logic              unread1;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              tend_irq;
        logic              rerr_irq;
        logic              lp_state;
    } sswr_state_t;

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic [2:0] prev;
    } sswr_samp_t;

endpackage

// ===== inc/sswr_pin_if.sv
// Carrier for the synchronised serial pins and their edges.
// Assumes every signal is on the pclk domain.
`timescale 1ns/1ps
`default_nettype none
interface sswr_pin_if;
    logic sck_rise;  // Serial clock rising edge, one-cycle pulse
    logic sck_fall;  // Serial clock falling edge, one-cycle pulse
    logic rxd_lvl;   // Receive data level
    logic rxd_fall;  // Receive data falling edge (start bit)
    logic sdi_lvl;   // Clocked-channel data level

    modport sampler (output sck_rise, sck_fall, rxd_lvl, rxd_fall, sdi_lvl);
    modport core    (input  sck_rise, sck_fall, rxd_lvl, rxd_fall, sdi_lvl);
endinterface
`default_nettype wire

// ===== rtl/sswr_pin_sampler.sv
// Two-flop synchronisers and edge finders for the serial pins.
// Assumes pins are asynchronous to pclk; bit 0 clock, 1 rx data, 2 csi data.
`timescale 1ns/1ps
`default_nettype none
module sswr_pin_sampler
    import sswr_pkg::*;
(
    input  wire logic   pclk,     // System clock
    input  wire logic   presetn,  // Async reset, active low
    input  wire logic [2:0] pins, // Raw pin levels
    sswr_pin_if.sampler pin       // Synchronised levels and edges
);
    sswr_samp_t s_r;
    sswr_samp_t s_nxt;

    // Only the second stage and its delayed copy feed edge logic
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pins;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    // Idle-high reset avoids false edges after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{meta: 3'h7, sync: 3'h7, prev: 3'h7};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pin.sck_rise = s_r.sync[0] & ~s_r.prev[0];
    assign pin.sck_fall = ~s_r.sync[0] & s_r.prev[0];
    assign pin.rxd_lvl  = s_r.sync[1];
    assign pin.rxd_fall = ~s_r.sync[1] & s_r.prev[1];
    assign pin.sdi_lvl  = s_r.sync[2];
endmodule
`default_nettype wire

// ===== rtl/sswr_top.sv
// Low-power receive path of a serial unit: clocked channel 0 and async channel 1
// receive while the CPU is stopped. Assumes cpu_stop and hs_osc_sel come from
// pclk-domain logic; serial pins are asynchronous and are synchronised here.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - In stop, a valid serial clock edge enters low-power receive on channel 0.
// - In stop, a start-bit edge on receive data begins async reception.
// - With wake enable set, channel 1 buffer-full and overrun flags stay unchanged.
// - Error interrupt follows the error enable and suppress bits.
// - With suppress set, errors set no flag and raise no error interrupt.
// - Only async instance zero may enter low-power receive on channel 1.
// - Error enable clear: no error interrupt, transfer end still raised.
// - Error enable set, suppress clear: errors raise the error interrupt.
module sswr_top
    import sswr_pkg::*;
#(
    parameter int CHAN_INSTANCE = 0 // Async channel instance number
) (
    input  wire logic        pclk,                    // 100 MHz system clock
    input  wire logic        presetn,                 // Async reset, active low
    input  wire logic        psel,                    // APB select
    input  wire logic        penable,                 // APB enable
    input  wire logic        pwrite,                  // APB direction, high = write
    input  wire logic [7:0]  paddr,                   // APB byte address
    input  wire logic [31:0] pwdata,                  // APB write data
    output logic      [31:0] prdata,                  // APB read data
    output logic             pready,                  // APB ready
    output logic             pslverr,                 // APB error on unmapped address
    input  wire logic        cpu_stop,                // CPU is in the stop state
    input  wire logic        hs_osc_sel,              // High-speed oscillator clocks the unit
    input  wire logic        serial_clock_pin,        // Clocked-channel serial clock
    input  wire logic        csi_data_pin,            // Clocked-channel data in
    input  wire logic        receive_data_pin,        // Async receive data
    output logic             transfer_end_interrupt,  // Reception done, one-cycle pulse
    output logic             receive_error_interrupt, // Receive error, one-cycle pulse
    output logic             lowpower_receive_state,  // A low-power reception is running
    output logic             chan0_enable_status      // Channel 0 enabled
);
    localparam sswr_state_t RST = '{mode: ST_IDLE, ps: RST_PRESCALE, div: RST_DIV,
                                    default: '0};

    sswr_state_t      s_r;
    sswr_state_t      s_nxt;
    sswr_pin_if       pin ();
    logic             acc_first;
    logic             acc_done;
    logic             lp_ok;
    logic             uart_ok;
    logic             uart_tick;
    logic             uart_end;
    logic             frame_pe;
    logic             frame_fe;
    logic             frame_err;
    logic [CNT_W-1:0] bit_len;
    logic [31:0]      rd_mux;
    logic             mapped;

    sswr_pin_sampler u_sampler (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    ({csi_data_pin, receive_data_pin, serial_clock_pin}),
        .pin     (pin)
    );

    // APB phases: one wait state, completion on the second access cycle
    assign acc_first = psel & penable & ~s_r.pready;
    assign acc_done  = psel & penable & s_r.pready;

    // Low-power receive is honoured only with the unit on the fast oscillator
    assign lp_ok   = s_r.wake_en & hs_osc_sel & cpu_stop;
    assign uart_ok = lp_ok & s_r.en1 & (CHAN_INSTANCE == 0);

    // Bit time in pclk cycles from divider and prescaler
    assign bit_len = CNT_W'((CNT_W'(s_r.div) + CNT_W'(1)) << s_r.ps);

    // Async frame end and its error terms
    assign uart_tick = (s_r.mode == ST_UART) & s_r.en1 & (s_r.baud == '0);
    assign uart_end  = uart_tick & (s_r.bitcnt == STOP_SLOT);
    assign frame_fe  = ~pin.rxd_lvl;
    assign frame_pe  = s_r.parity_en & s_r.par_acc;
    assign frame_err = frame_fe | frame_pe | s_r.unread1;

    // Read multiplexer and address map
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            OFS_STANDBY:  rd_mux = {30'h0, s_r.suppress, s_r.wake_en};
            OFS_START:    rd_mux = 32'h0000_0000;
            OFS_STOP:     rd_mux = 32'h0000_0000;
            OFS_STATUS:   rd_mux = {24'h0, s_r.lp_state, s_r.ove, s_r.fef, s_r.pef,
                                    s_r.ovf1, s_r.buf_full, s_r.en1, s_r.en0};
            OFS_CH0_DATA: rd_mux = {24'h0, s_r.ch0_data};
            // Divider bits read zero while the channel runs
            OFS_CH1_DATA: rd_mux = {16'h0, (s_r.en1 ? 7'h00 : s_r.div), 1'b0, s_r.ch1_data};
            OFS_PRESCALE: rd_mux = {28'h0, s_r.ps};
            OFS_MODE:     rd_mux = {30'h0, s_r.parity_en, s_r.eie};
            default:      mapped = 1'b0;
        endcase
    end

    // Next state: bus side first, then reception, so hardware sets win over clears
    always_comb begin
        s_nxt          = s_r;
        s_nxt.tend_irq = 1'b0;
        s_nxt.rerr_irq = 1'b0;
        s_nxt.pready   = acc_first;
        if (acc_first) begin
            s_nxt.prdata  = rd_mux;
            s_nxt.pslverr = ~mapped;
        end
        if (acc_done && pwrite && mapped) begin
            unique case (paddr)
                OFS_STANDBY: begin
                    s_nxt.wake_en  = pwdata[SSC_WAKE_BIT];
                    s_nxt.suppress = pwdata[SSC_SUPPRESS_BIT];
                end
                OFS_START: begin
                    if (pwdata[CH0_TRIG_BIT]) s_nxt.en0 = 1'b1;
                    if (pwdata[CH1_TRIG_BIT]) s_nxt.en1 = 1'b1;
                end
                OFS_STOP: begin
                    if (pwdata[CH0_TRIG_BIT]) s_nxt.en0 = 1'b0;
                    if (pwdata[CH1_TRIG_BIT]) s_nxt.en1 = 1'b0;
                end
                OFS_STATUS: begin
                    if (pwdata[ERR_PEF_BIT]) s_nxt.pef = 1'b0;
                    if (pwdata[ERR_FEF_BIT]) s_nxt.fef = 1'b0;
                    if (pwdata[ERR_OVE_BIT]) s_nxt.ove = 1'b0;
                end
                OFS_CH1_DATA: begin
                    // Divider is frozen while the channel runs
                    if (!s_r.en1) s_nxt.div = pwdata[DIV_MSB:DIV_LSB];
                end
                OFS_PRESCALE: begin
                    if (!s_r.en1) s_nxt.ps = pwdata[PS_W-1:0];
                end
                OFS_MODE: begin
                    s_nxt.eie       = pwdata[MODE_EIE_BIT];
                    s_nxt.parity_en = pwdata[MODE_PARITY_BIT];
                end
                default: s_nxt.eie = s_r.eie;
            endcase
        end
        // Reading channel 1 data frees the buffer
        if (acc_done && !pwrite && paddr == OFS_CH1_DATA) begin
            s_nxt.unread1 = 1'b0;
            if (!s_r.wake_en) s_nxt.buf_full = 1'b0;
        end

        unique case (s_r.mode)
            ST_IDLE: begin
                if (lp_ok && (s_r.en0 || s_r.en1)) s_nxt.mode = ST_ARMED;
            end
            ST_ARMED: begin
                if (!lp_ok) begin
                    s_nxt.mode = ST_IDLE;
                end else if (s_r.en0 && pin.sck_fall) begin
                    s_nxt.mode   = ST_CSI;
                    s_nxt.bitcnt = 4'h0;
                end else if (uart_ok && pin.rxd_fall) begin
                    s_nxt.mode    = ST_UART;
                    s_nxt.bitcnt  = 4'h0;
                    s_nxt.par_acc = 1'b0;
                    s_nxt.baud    = bit_len >> 1;
                end
            end
            ST_CSI: begin
                // A stop request abandons the byte in progress
                if (!s_r.en0) begin
                    s_nxt.mode = ST_IDLE;
                end else if (pin.sck_rise) begin
                    s_nxt.shift  = {s_r.shift[6:0], pin.sdi_lvl};
                    s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                    if (s_r.bitcnt == 4'h7) begin
                        s_nxt.ch0_data = {s_r.shift[6:0], pin.sdi_lvl};
                        s_nxt.tend_irq = 1'b1;
                        s_nxt.mode     = ST_ARMED;
                    end
                end
            end
            ST_UART: begin
                if (!s_r.en1) begin
                    s_nxt.mode = ST_IDLE;
                end else if (!uart_tick) begin
                    s_nxt.baud = s_r.baud - CNT_W'(1);
                end else begin
                    s_nxt.baud = bit_len - CNT_W'(1);
                    if (s_r.bitcnt == 4'h0) begin
                        // Too short a pulse is not a start bit; rearm
                        if (pin.rxd_lvl) s_nxt.mode = ST_ARMED;
                        else s_nxt.bitcnt = 4'h1;
                    end else if (s_r.bitcnt <= LAST_DATA) begin
                        s_nxt.shift   = {pin.rxd_lvl, s_r.shift[7:1]};
                        s_nxt.par_acc = s_r.par_acc ^ pin.rxd_lvl;
                        s_nxt.bitcnt  = (s_r.bitcnt == LAST_DATA && !s_r.parity_en) ?
                                        STOP_SLOT : s_r.bitcnt + 4'h1;
                    end else if (s_r.bitcnt == PARITY_SLOT) begin
                        s_nxt.par_acc = s_r.par_acc ^ pin.rxd_lvl;
                        s_nxt.bitcnt  = STOP_SLOT;
                    end else begin
                        s_nxt.ch1_data = s_r.shift;
                        s_nxt.unread1  = 1'b1;
                        s_nxt.mode     = ST_ARMED;
                        s_nxt.tend_irq = 1'b1;
                        // Buffer flags are held while waking is enabled
                        if (!s_r.wake_en) begin
                            s_nxt.buf_full = 1'b1;
                            if (s_r.unread1) s_nxt.ovf1 = 1'b1;
                        end
                        if (!s_r.suppress) begin
                            if (frame_pe) s_nxt.pef = 1'b1;
                            if (frame_fe) s_nxt.fef = 1'b1;
                            if (s_r.unread1) s_nxt.ove = 1'b1;
                        end
                        s_nxt.rerr_irq = frame_err & s_r.eie & ~s_r.suppress;
                    end
                end
            end
            default: s_nxt.mode = ST_IDLE;
        endcase
        s_nxt.lp_state = (s_nxt.mode == ST_CSI) || (s_nxt.mode == ST_UART);
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata                  = s_r.prdata;
    assign pready                  = s_r.pready;
    assign pslverr                 = s_r.pslverr;
    assign transfer_end_interrupt  = s_r.tend_irq;
    assign receive_error_interrupt = s_r.rerr_irq;
    assign lowpower_receive_state  = s_r.lp_state;
    assign chan0_enable_status     = s_r.en0;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_end_pulse;
        s_r.tend_irq ##1 !s_r.tend_irq;
    endsequence

    sequence seq_csi_entry;
        (s_r.mode == ST_ARMED) && lp_ok && s_r.en0 && pin.sck_fall;
    endsequence

    chk_csi_wake_entry: assert property (
        seq_csi_entry |=> (s_r.mode == ST_CSI) && lowpower_receive_state)
        else $error("clocked channel missed its wake edge");
    chk_uart_start_entry: assert property (
        (s_r.mode == ST_ARMED) && uart_ok && pin.rxd_fall && !(s_r.en0 && pin.sck_fall)
        |=> (s_r.mode == ST_UART) && (s_r.baud == (bit_len >> 1)))
        else $error("async channel missed its start edge");
    chk_flags_frozen: assert property (
        s_r.wake_en |=> $stable(s_r.buf_full) && $stable(s_r.ovf1))
        else $error("buffer flags changed with wake enabled");
    chk_suppress_no_flag: assert property (
        s_r.suppress |=> !$rose(s_r.pef) && !$rose(s_r.fef) && !$rose(s_r.ove)
                         && !s_r.rerr_irq)
        else $error("suppressed error still flagged");
    chk_eie_off_quiet: assert property (
        !s_r.eie |=> !receive_error_interrupt)
        else $error("error interrupt with enable clear");
    chk_err_irq_raised: assert property (
        uart_end && frame_err && s_r.eie && !s_r.suppress |=> receive_error_interrupt)
        else $error("error interrupt not raised");
    chk_err_irq_cause: assert property (
        receive_error_interrupt |-> $past(s_r.eie) && !$past(s_r.suppress) && $past(uart_end))
        else $error("error interrupt without its cause");
    chk_end_pulse: assert property (
        uart_end |=> seq_end_pulse)
        else $error("transfer end not a single pulse");
    chk_instance_only: assert property (
        (CHAN_INSTANCE != 0) |-> (s_r.mode != ST_UART))
        else $error("non-zero instance entered low-power receive");
endmodule
`default_nettype wire

// ===== dv/sswr_far_end.sv
// Far-side serial transmitter: drives the clocked channel and the async line.
// Assumes the bench calls its tasks; pins are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module sswr_far_end (
    output logic serial_clock_pin, // Idle high, runs only within frames
    output logic csi_data_pin,     // Clocked data, changes at the clock falling edge
    output logic receive_data_pin  // Async data, idle high
);
    // Idle levels at time zero so the synchronisers see no edge at release
    initial begin
        serial_clock_pin = 1'b1;
        csi_data_pin     = 1'b1;
        receive_data_pin = 1'b1;
    end

    // Falling edge wakes the channel, rising edges carry bits MSB first
    task automatic send_csi(input logic [7:0] b);
        #3; // Keep pin changes off the pclk edge so the sampler never races them
        // One bit per 125 ns spans over twelve pclk cycles, so every edge is seen
        for (int i = 7; i >= 0; i--) begin
            csi_data_pin     = b[i];
            serial_clock_pin = 1'b0;
            #62.5;
            serial_clock_pin = 1'b1;
            #62.5;
        end
        csi_data_pin = ~b[0]; // Released line must not look held
    endtask

    // Start bit, eight bits LSB first, then a stop bit that may be broken
    task automatic send_uart(input logic [7:0] b, input logic stop_ok, input realtime bt);
        #3; // Off the pclk edge; bit time matches the programmed divider
        receive_data_pin = 1'b0;
        #bt;
        for (int i = 0; i < 8; i++) begin
            receive_data_pin = b[i];
            #bt;
        end
        receive_data_pin = stop_ok;
        #bt;
        receive_data_pin = 1'b1;
        #bt;
    endtask
endmodule
`default_nettype wire

// ===== dv/serial_lowpower_receive_state_wake_receive_bench.sv
// Self-checking bench of the low-power receive block over APB.
// Assumes sswr_pkg offsets; a second instance checks the channel restriction.
`timescale 1ns/1ps
`default_nettype none
module serial_lowpower_receive_state_wake_receive_bench;
    import sswr_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, cpu_stop, hs_osc_sel;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, transfer_end_interrupt, receive_error_interrupt;
    logic        lowpower_receive_state, chan0_enable_status, tend_b;
    wire logic   serial_clock_pin, csi_data_pin, receive_data_pin;
    int          num_errors = 0, comparisons = 0, tend_cnt = 0, rerr_cnt = 0;
    int          tend_b_cnt = 0, lp_cnt = 0;

    sswr_top i_sswr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cpu_stop, .hs_osc_sel, .serial_clock_pin,
        .csi_data_pin, .receive_data_pin, .transfer_end_interrupt,
        .receive_error_interrupt, .lowpower_receive_state, .chan0_enable_status);
    // Same bus and pins, but an async instance that may not wake
    sswr_top #(.CHAN_INSTANCE(1)) i_sswr_top_1 (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .cpu_stop,
        .hs_osc_sel, .serial_clock_pin, .csi_data_pin, .receive_data_pin,
        .transfer_end_interrupt(tend_b), .receive_error_interrupt(),
        .lowpower_receive_state(), .chan0_enable_status());
    sswr_far_end i_sswr_far_end (.serial_clock_pin, .csi_data_pin, .receive_data_pin);

    always #5 pclk = ~pclk;

    // Pulses are one cycle wide, so count them at every edge
    always @(posedge pclk) begin
        if (transfer_end_interrupt === 1'b1) tend_cnt++;
        if (receive_error_interrupt === 1'b1) rerr_cnt++;
        if (tend_b === 1'b1) tend_b_cnt++;
        if (lowpower_receive_state === 1'b1) lp_cnt++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A slave that never answers ends the run as a failure
        if (n >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Detection takes three cycles and the pulse one more
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rd(OFS_STATUS, r);
        chk(r, 32'h0);
        rd(OFS_MODE, r);
        chk(r, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask

    task automatic t_csi();
        logic [31:0] r;
        int          b;
        wr(OFS_MODE, 32'h0);
        wr(OFS_STANDBY, 32'h1);
        wr(OFS_START, 32'h1);
        cpu_stop <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({31'h0, chan0_enable_status}, 32'h1);
        b = tend_cnt;
        lp_cnt = 0;
        i_sswr_far_end.send_csi(8'hA5);
        settle();
        chk(32'(tend_cnt - b), 32'h1);
        chk({31'h0, lp_cnt > 0}, 32'h1);
        rd(OFS_CH0_DATA, r);
        chk({24'h0, r[7:0]}, 32'hA5);
        cpu_stop <= 1'b0;
        wr(OFS_STOP, 32'h1);
        wr(OFS_STANDBY, 32'h0);
        rd(OFS_STATUS, r);
        chk(r, 32'h0);
        chk({31'h0, chan0_enable_status}, 32'h0);
    endtask

    // Table bits: parity enable, error enable, suppress, stop bit good (parity bit if enabled)
    task automatic t_uart();
        logic [3:0]  tbl [6] = '{4'b0101, 4'b0100, 4'b0000, 4'b0010, 4'b0110, 4'b1101};
        logic [31:0] r;
        logic        fe, pe;
        int          b, e, bb;
        wr(OFS_PRESCALE, 32'h1);
        wr(OFS_CH1_DATA, 32'h3 << DIV_LSB);
        wr(OFS_START, 32'h2);
        bb = tend_b_cnt;
        for (int k = 0; k < 6; k++) begin
            cpu_stop <= 1'b0;
            wr(OFS_MODE, {30'h0, tbl[k][3], tbl[k][2]});
            wr(OFS_STATUS, 32'h70);
            rd(OFS_CH1_DATA, r);
            wr(OFS_STANDBY, {30'h0, tbl[k][1], 1'b1});
            cpu_stop <= 1'b1;
            repeat (2) @(posedge pclk);
            b = tend_cnt;
            e = rerr_cnt;
            i_sswr_far_end.send_uart(8'h30 + 8'(k), tbl[k][0], 80.0);
            settle();
            // With parity on, the stop slot sees the idle line; 8'h35 holds an even count
            fe = ~tbl[k][0] & ~tbl[k][1] & ~tbl[k][3];
            pe = tbl[k][0] & ~tbl[k][1] & tbl[k][3];
            chk(32'(tend_cnt - b), 32'h1);
            chk(32'(rerr_cnt - e), {31'h0, (fe | pe) & tbl[k][2]});
            rd(OFS_STATUS, r);
            chk({24'h0, r[7:0]}, {26'h0, fe, pe, 4'b0010});
            rd(OFS_CH1_DATA, r);
            chk({24'h0, r[7:0]}, 32'h30 + k);
        end
        chk(32'(tend_b_cnt - bb), 32'h0);
        cpu_stop <= 1'b0;
        wr(OFS_STOP, 32'h2);
        wr(OFS_STANDBY, 32'h0);
    endtask

    // A clock burst must not wake the channel unless stopped and on the fast oscillator
    task automatic t_gate();
        int b;
        for (int k = 0; k < 2; k++) begin
            wr(OFS_STANDBY, 32'h1);
            wr(OFS_START, 32'h1);
            cpu_stop   <= (k == 1);
            hs_osc_sel <= (k == 0);
            repeat (2) @(posedge pclk);
            b = tend_cnt;
            i_sswr_far_end.send_csi(8'h3C);
            settle();
            chk(32'(tend_cnt - b), 32'h0);
            wr(OFS_STOP, 32'h1);
            wr(OFS_STANDBY, 32'h0);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence after a four-cycle reset
    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        {psel, penable, pwrite, cpu_stop} = 4'h0;
        hs_osc_sel = 1'b1;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_csi();
        t_uart();
        t_gate();
        tally_and_finish();
    end

    // The whole run needs well under 100 us
    initial begin
        #200us;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
